// ===== hdl/ltc_ctrl.sv
// ltc_ctrl: exception entry/return arbitration, tail-chaining, fp context control, continuation
// assumes the pipeline, stacking engine and exception sources run on sys_clk_i
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps

module ltc_ctrl (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // avalon-mm slave
  input  wire logic [ltc_pkg::AV_ADDR_W-1:0] avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic [31:0]                      avs_readdata_o,
  output logic                             avs_waitrequest_o,
  // exception sources and pipeline
  input  wire ltc_pkg::ltc_exc_t           new_exc_i,
  input  wire logic                        entry_start_i,
  input  wire logic                        entry_done_i,
  input  wire logic                        return_start_i,
  input  wire logic                        return_done_i,
  input  wire logic [ltc_pkg::PRIO_W-1:0]  preempted_prio_i,
  input  wire logic [ltc_pkg::PRIO_W-1:0]  return_prio_i,
  input  wire logic                        background_secure_i,
  input  wire logic                        target_secure_i,
  input  wire logic                        dbgmon_num_match_i,
  input  wire ltc_pkg::ltc_cont_t          cont_i,
  input  wire logic                        single_load_abort_i,
  // outputs
  output ltc_pkg::ltc_exc_t                take_exc_o,
  output logic                             take_pulse_o,
  output logic                             pend_orig_o,
  output logic                             skip_unstack_o,
  output logic                             push_additional_o,
  output logic                             rollback_additional_o,
  output logic                             stack_fp_o,
  output logic                             clear_fp_o,
  output logic                             thread_hold_o,
  output logic                             callee_stacking_flag_o,
  output logic                             return_token_zero_o,
  output logic [7:0]                       continuation_field_o,
  output logic                             dest_write_block_o
);
  import ltc_pkg::*;

  // numerically smaller wins, ties do not
  function automatic logic outranks(input logic [PRIO_W-1:0] a, input logic [PRIO_W-1:0] b);
    outranks = (a < b);
  endfunction

  // nonsecure demotion folds the value into the high half of the range
  function automatic logic [PRIO_W-1:0] eff_prio(input ltc_exc_t e, input logic demote);
    eff_prio = (demote && !e.secure) ? ((e.prio >> 1) | PRIO_DEMOTE_BIT) : e.prio;
  endfunction

  // register state
  logic [5:0]  ctrl_q, ctrl_d;
  logic        rd_valid_q, rd_valid_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wreq_q, wreq_d;

  // control state
  ltc_state_t  state_q, state_d;
  ltc_exc_t    cur_q, cur_d;
  ltc_exc_t    orig_q, orig_d;
  ltc_exc_t    defer_q, defer_d;
  ltc_exc_t    take_q, take_d;
  logic        take_pulse_q, take_pulse_d;
  logic        pend_orig_q, pend_orig_d;
  logic        skip_unstack_q, skip_unstack_d;
  logic        push_add_q, push_add_d;
  logic        rollback_q, rollback_d;
  logic        stack_fp_q, stack_fp_d;
  logic        clear_fp_q, clear_fp_d;
  logic        hold_q, hold_d;
  logic        callee_stacking_flag_q, callee_stacking_flag_d;
  logic        tok_zero_q, tok_zero_d;
  logic [7:0]  cont_q, cont_d;
  logic        dest_blk_q, dest_blk_d;
  logic        cur_secure_q, cur_secure_d;

  logic        demote;
  logic        is_dbgmon;
  ltc_exc_t    arr;
  ltc_exc_t    esc;

  assign demote    = ctrl_q[CTRL_DEMOTE];
  assign is_dbgmon = dbgmon_num_match_i || (new_exc_i.num == EXC_DBGMON);

  always_comb begin
    arr      = new_exc_i;
    arr.prio = eff_prio(new_exc_i, demote);
    esc         = arr;
    esc.num     = EXC_ESCALATION_FAULT;
    esc.prio    = PRIO_ESCALATION_FAULT;
    esc.secure  = arr.secure;
  end

  // register bus: one-cycle wait, answer on second edge
  always_comb begin
    ctrl_d     = ctrl_q;
    rd_valid_d = 1'b0;
    rdata_d    = rdata_q;
    // write lands on the edge the master sees the answer
    if (avs_write_i && rd_valid_q && (avs_address_i == REG_CTRL) && avs_byteenable_i[0]) begin
      ctrl_d = avs_writedata_i[5:0];
    end
    if (avs_write_i && !rd_valid_q) begin
      rd_valid_d = 1'b1;
    end else if (avs_read_i && !rd_valid_q) begin
      rd_valid_d = 1'b1;
      case (avs_address_i)
        REG_CTRL:   rdata_d = {26'h0, ctrl_q};
        REG_STATUS: rdata_d = {20'h0, callee_stacking_flag_q, tok_zero_q, pend_orig_q, defer_q.valid,
                               hold_q, cur_secure_q, 3'h0, state_q};
        REG_ORIG:   rdata_d = {6'h0, orig_q.valid, orig_q.num, orig_q.prio, 8'h0};
        REG_CONT:   rdata_d = {24'h0, cont_q};
        default:    rdata_d = UNMAPPED_VAL;
      endcase
    end
    wreq_d = !rd_valid_d;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q     <= CTRL_RST;
      rd_valid_q <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      wreq_q     <= 1'b1;
    end else begin
      ctrl_q     <= ctrl_d;
      rd_valid_q <= rd_valid_d;
      rdata_q    <= rdata_d;
      wreq_q     <= wreq_d;
    end
  end

  // exception sequencing
  always_comb begin
    state_d        = state_q;
    cur_d          = cur_q;
    orig_d         = orig_q;
    defer_d        = defer_q;
    take_d         = take_q;
    take_pulse_d   = 1'b0;
    pend_orig_d    = pend_orig_q;
    skip_unstack_d = 1'b0;
    push_add_d     = 1'b0;
    rollback_d     = 1'b0;
    stack_fp_d     = stack_fp_q;
    clear_fp_d     = 1'b0;
    hold_d         = hold_q;
    callee_stacking_flag_d         = callee_stacking_flag_q;
    tok_zero_d     = 1'b0;
    cur_secure_d   = cur_secure_q;
    case (state_q)
      LTC_IDLE, LTC_ACTIVE: begin
        hold_d = 1'b0;
        if (entry_start_i && arr.valid) begin
          state_d  = LTC_ENTRY;
          cur_d    = arr;
          stack_fp_d = ctrl_q[CTRL_FP_PRES] && ctrl_q[CTRL_FPCA];
        end
      end
      LTC_ENTRY: begin
        if (arr.valid && !entry_start_i) begin
          if (arr.derived) begin
            if (!outranks(arr.prio, preempted_prio_i)) begin
              // a standing derived arrival is escalated once only
              if (!is_dbgmon && (cur_q.num != EXC_ESCALATION_FAULT)) begin
                orig_d      = cur_q.valid ? cur_q : orig_q;
                pend_orig_d = 1'b1;
                cur_d       = esc;
              end
            end else if (outranks(arr.prio, cur_q.prio)) begin
              orig_d      = cur_q;
              pend_orig_d = 1'b1;
              cur_d       = arr;
            end
          end else if (outranks(arr.prio, cur_q.prio) && ctrl_q[CTRL_ASYNC_LA]) begin
            orig_d      = cur_q;
            pend_orig_d = 1'b1;
            cur_d       = arr;
            if (arr.secure && !cur_q.secure && background_secure_i) begin
              rollback_d = ctrl_q[CTRL_ROLLBACK];
              tok_zero_d = !ctrl_q[CTRL_ROLLBACK];
            end
          end else if (arr.num != cur_q.num) begin
            // async preemption disabled or not higher, keep pending
            defer_d = arr;
          end
        end
        if (entry_done_i) begin
          state_d      = LTC_ACTIVE;
          take_d       = cur_d;
          take_pulse_d = 1'b1;
          cur_secure_d = cur_d.secure;
        end
      end
      LTC_RETURN: begin
        // thread held during return and tail-chain
        hold_d = 1'b1;
        // fp clear on exception return only when CTRL_CLRRET, CTRL_FPCA and CTRL_FP_PRES are all set
        clear_fp_d = ctrl_q[CTRL_FP_PRES] && ctrl_q[CTRL_CLRRET] && ctrl_q[CTRL_FPCA];
        if (arr.valid && arr.derived && !outranks(arr.prio, return_prio_i)) begin
          // debug trap ignored, else escalate and chain
          if (!is_dbgmon) begin
            cur_d   = esc;
            state_d = LTC_TAIL;
          end
        end else if (arr.valid && outranks(arr.prio, return_prio_i)) begin
          cur_d   = arr;
          state_d = LTC_TAIL;
        end else if (pend_orig_q && outranks(orig_q.prio, return_prio_i)) begin
          cur_d       = orig_q;
          pend_orig_d = 1'b0;
          state_d     = LTC_TAIL;
        // suppressed derived raised at final return
        end else if (defer_q.valid && outranks(defer_q.prio, return_prio_i)) begin
          cur_d         = defer_q;
          defer_d.valid = 1'b0;
          state_d       = LTC_TAIL;
        end else if (return_done_i) begin
          state_d = LTC_IDLE;
          hold_d  = 1'b0;
        end
        if (state_d == LTC_TAIL) begin
          skip_unstack_d = 1'b1;
        end
      end
      LTC_TAIL: begin
        if (arr.valid && !arr.derived && ctrl_q[CTRL_ASYNC_LA] &&
            outranks(arr.prio, cur_q.prio)) begin
          if (cur_q.derived) begin
            defer_d = cur_q;
          end
          cur_d = arr;
        end else begin
          state_d      = LTC_ACTIVE;
          take_d       = cur_q;
          take_pulse_d = 1'b1;
          cur_secure_d = cur_q.secure;
          // secure to nonsecure pushes additional context only while callee_stacking_flag_q is set, and sets the flag
          if (background_secure_i && cur_secure_q && !cur_q.secure) begin
            if (callee_stacking_flag_q) begin
              push_add_d = 1'b1;
              callee_stacking_flag_d     = 1'b1;
            end else begin
              callee_stacking_flag_d = 1'b1;
            end
          end else if (background_secure_i && !cur_secure_q && cur_q.secure) begin
            callee_stacking_flag_d = 1'b0;
          end
        end
      end
      default: state_d = LTC_IDLE;
    endcase
    if (return_start_i && state_q == LTC_ACTIVE) begin
      state_d = LTC_RETURN;
    end
    if (entry_start_i && state_q == LTC_ENTRY) begin
      defer_d = defer_q;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q        <= LTC_IDLE;
      cur_q          <= '0;
      orig_q         <= '0;
      defer_q        <= '0;
      take_q         <= '0;
      take_pulse_q   <= 1'b0;
      pend_orig_q    <= 1'b0;
      skip_unstack_q <= 1'b0;
      push_add_q     <= 1'b0;
      rollback_q     <= 1'b0;
      stack_fp_q     <= 1'b0;
      clear_fp_q     <= 1'b0;
      hold_q         <= 1'b0;
      callee_stacking_flag_q         <= 1'b1;
      tok_zero_q     <= 1'b0;
      cur_secure_q   <= 1'b0;
    end else begin
      state_q        <= state_d;
      cur_q          <= cur_d;
      orig_q         <= orig_d;
      defer_q        <= defer_d;
      take_q         <= take_d;
      take_pulse_q   <= take_pulse_d;
      pend_orig_q    <= pend_orig_d;
      skip_unstack_q <= skip_unstack_d;
      push_add_q     <= push_add_d;
      rollback_q     <= rollback_d;
      stack_fp_q     <= stack_fp_d;
      clear_fp_q     <= clear_fp_d;
      hold_q         <= hold_d;
      callee_stacking_flag_q         <= callee_stacking_flag_d;
      tok_zero_q     <= tok_zero_d;
      cur_secure_q   <= cur_secure_d;
    end
  end

  // continuation state capture
  always_comb begin
    cont_d     = cont_q;
    dest_blk_d = single_load_abort_i;
    if (take_pulse_d && cont_i.valid && (ctrl_q[CTRL_FP_PRES] || !cont_i.fp)) begin
      // first register or fp doubleword left
      // only bits 5:2 may be nonzero
      cont_d = 8'h00;
      cont_d[CONT_REG_MSB:CONT_REG_LSB] = cont_i.reg_num;
    end else if (take_pulse_d) begin
      cont_d = 8'h00;
    end
    if (single_load_abort_i) begin
      dest_blk_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cont_q     <= 8'h00;
      dest_blk_q <= 1'b0;
    end else begin
      cont_q     <= cont_d;
      dest_blk_q <= dest_blk_d;
    end
  end

  assign avs_readdata_o         = rdata_q;
  assign avs_waitrequest_o      = wreq_q;
  assign take_exc_o             = take_q;
  assign take_pulse_o           = take_pulse_q;
  assign pend_orig_o            = pend_orig_q;
  assign skip_unstack_o         = skip_unstack_q;
  assign push_additional_o      = push_add_q;
  assign rollback_additional_o  = rollback_q;
  assign stack_fp_o             = stack_fp_q;
  assign clear_fp_o             = clear_fp_q;
  assign thread_hold_o          = hold_q;
  assign callee_stacking_flag_o = callee_stacking_flag_q;
  assign return_token_zero_o    = tok_zero_q;
  assign continuation_field_o   = cont_q;
  assign dest_write_block_o     = dest_blk_q;

endmodule

// ===== common/ltc_pkg.sv
// ltc_pkg: shared types, register map and constants for the late-arrival / tail-chain controller
// assumes one 20 MHz clock and an Avalon-MM byte-addressed register slave
package ltc_pkg;

  localparam int unsigned PRIO_W    = 8;
  localparam int unsigned EXC_W     = 9;
  localparam int unsigned AV_ADDR_W = 4;

  // byte offsets of the register words
  localparam logic [AV_ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [AV_ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [AV_ADDR_W-1:0] REG_ORIG   = 4'h8;
  localparam logic [AV_ADDR_W-1:0] REG_CONT   = 4'hc;

  // ctrl field positions
  localparam int unsigned CTRL_DEMOTE   = 0;
  localparam int unsigned CTRL_FPCA     = 1;
  localparam int unsigned CTRL_CLRRET   = 2;
  localparam int unsigned CTRL_ASYNC_LA = 3;
  localparam int unsigned CTRL_ROLLBACK = 4;
  localparam int unsigned CTRL_FP_PRES  = 5;
  localparam logic [5:0]  CTRL_RST      = 6'h20;

  localparam logic [31:0] UNMAPPED_VAL  = 32'h0000_0000;

  localparam logic [EXC_W-1:0]  EXC_ESCALATION_FAULT = 9'h003;
  localparam logic [EXC_W-1:0]  EXC_DBGMON    = 9'h00c;
  localparam logic [PRIO_W-1:0] PRIO_ESCALATION_FAULT = 8'hff; // escalation target is fixed at 8'hff, the least urgent level
  localparam logic [PRIO_W-1:0] PRIO_DEMOTE_BIT = 8'h80;

  // continuation field layout
  localparam int unsigned CONT_REG_LSB = 2;
  localparam int unsigned CONT_REG_MSB = 5;

  typedef enum logic [2:0] {
    LTC_IDLE   = 3'b000,
    LTC_ENTRY  = 3'b001,
    LTC_ACTIVE = 3'b010,
    LTC_RETURN = 3'b011,
    LTC_TAIL   = 3'b100
  } ltc_state_t;

  typedef struct packed {
    logic              valid;
    logic [EXC_W-1:0]  num;
    logic [PRIO_W-1:0] prio;
    logic              secure;
    logic              derived;
  } ltc_exc_t;

  typedef struct packed {
    logic       valid;
    logic       fp;
    logic [3:0] reg_num;
    logic       is_load;
  } ltc_cont_t;

endpackage

// ===== dv/ltc_ctrl_sva.sv
// ltc_ctrl_sva: port-level checks for the late-arrival / tail-chain controller
// assumes it is bound onto ltc_ctrl and sees only its ports
`timescale 1ns/1ps
module ltc_ctrl_sva (
  input wire logic              sys_clk_i,
  input wire logic              rst_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic              avs_waitrequest_o,
  input wire ltc_pkg::ltc_exc_t take_exc_o,
  input wire logic              take_pulse_o,
  input wire logic              pend_orig_o,
  input wire logic              skip_unstack_o,
  input wire logic              thread_hold_o,
  input wire logic              return_token_zero_o,
  input wire logic [7:0]        continuation_field_o,
  input wire logic              single_load_abort_i,
  input wire logic              dest_write_block_o
);
  import ltc_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus request not answered");
  a_answer_once: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  a_take_valid: assert property (take_pulse_o |-> take_exc_o.valid)
    else $error("take pulse without valid exception");
  a_take_single: assert property (take_pulse_o |=> !take_pulse_o)
    else $error("take pulse too long");
  a_cont_format: assert property (continuation_field_o[7:6] == 2'h0
    && continuation_field_o[1:0] == 2'h0) else $error("continuation field malformed");
  a_dest_block: assert property (single_load_abort_i |=> dest_write_block_o)
    else $error("aborted load may write destination");
  a_skip_hold: assert property (skip_unstack_o |-> thread_hold_o)
    else $error("thread runs while tail-chaining");
  a_token_pulse: assert property (return_token_zero_o |=> !return_token_zero_o)
    else $error("token zero pulse too long");
  c_take: cover property (take_pulse_o && pend_orig_o);
  c_skip: cover property (skip_unstack_o);
  c_block: cover property (dest_write_block_o);
endmodule
bind ltc_ctrl ltc_ctrl_sva ltc_ctrl_sva_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .take_exc_o(take_exc_o), .take_pulse_o(take_pulse_o), .pend_orig_o(pend_orig_o),
  .skip_unstack_o(skip_unstack_o), .thread_hold_o(thread_hold_o),
  .return_token_zero_o(return_token_zero_o), .continuation_field_o(continuation_field_o),
  .single_load_abort_i(single_load_abort_i), .dest_write_block_o(dest_write_block_o));

// ===== dv/ltc_pipe_model.sv
// ltc_pipe_model: pipeline and stacking engine stand-in giving entry and return pulses
// assumes one-cycle go pulses from the bench and a delay of at least 1
`timescale 1ns/1ps
module ltc_pipe_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_entry_i,
  input  wire logic       go_return_i,
  input  wire logic [3:0] delay_i,
  output logic            entry_start_o,
  output logic            entry_done_o,
  output logic            return_start_o,
  output logic            return_done_o
);
  logic [3:0] cnt_q, cnt_d;
  logic       ret_q, ret_d, go_q, go_d;
  always_comb begin
    cnt_d = cnt_q;
    ret_d = ret_q;
    go_d  = go_entry_i || go_return_i;
    if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
    if (go_d) begin
      cnt_d = delay_i + 4'h1;
      ret_d = go_return_i;
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      ret_q <= 1'h0;
      go_q  <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      ret_q <= ret_d;
      go_q  <= go_d;
    end
  end
  // start one cycle after go, done delay cycles later
  assign entry_start_o  = go_q && !ret_q;
  assign return_start_o = go_q && ret_q;
  assign entry_done_o   = (cnt_q == 4'h1) && !ret_q;
  assign return_done_o  = (cnt_q == 4'h1) && ret_q;
endmodule

// ===== dv/ltc_ctrl_tb_top.sv
// ltc_ctrl_tb_top: self-checking bench for the late-arrival / tail-chain controller
// assumes ltc_pkg, the pipeline model and the bound checker are compiled first
`timescale 1ns/1ps
module ltc_ctrl_tb_top;
  import ltc_pkg::*;
  typedef struct {logic wr; logic [3:0] a; logic [31:0] wd; logic [31:0] ex;} ltc_row_t;
  logic        clk, rst, rd, wr, wait_o, go_e, go_r, ent_s, ent_d, ret_s, ret_d;
  logic        bsec, tsec, dbg, abort, take_p, pend_o, skip_o, hold_o, blk_o;
  logic        sfp_o, clr_o, cflag_o, skip_seen, clr_seen;
  logic        push_o, roll_o, tok_o, roll_seen, tok_seen;
  logic [3:0]  addr, dly;
  logic [31:0] wdata, rdata, rd_v;
  logic [7:0]  pre_p, ret_p, cont_o;
  ltc_exc_t    nexc, got, got_w;
  ltc_cont_t   cont;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  ltc_row_t    rows [7] = '{
    '{1'h0, REG_CTRL, 32'h0, 32'h20}, '{1'h0, REG_STATUS, 32'h0, 32'h800},
    '{1'h0, REG_CONT, 32'h0, 32'h0}, '{1'h1, REG_CTRL, 32'h3f, 32'h0},
    '{1'h0, REG_CTRL, 32'h0, 32'h3f}, '{1'h1, 4'h2, 32'hffff_ffff, 32'h0},
    '{1'h0, 4'h2, 32'h0, 32'h0}};

  ltc_pipe_model ltc_pipe_model_inst (.sys_clk_i(clk), .rst_i(rst), .go_entry_i(go_e),
    .go_return_i(go_r), .delay_i(dly), .entry_start_o(ent_s), .entry_done_o(ent_d),
    .return_start_o(ret_s), .return_done_o(ret_d));
  ltc_ctrl ltc_ctrl_inst (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .new_exc_i(nexc),
    .entry_start_i(ent_s), .entry_done_i(ent_d), .return_start_i(ret_s),
    .return_done_i(ret_d), .preempted_prio_i(pre_p), .return_prio_i(ret_p),
    .background_secure_i(bsec), .target_secure_i(tsec), .dbgmon_num_match_i(dbg),
    .cont_i(cont), .single_load_abort_i(abort), .take_exc_o(got_w), .take_pulse_o(take_p),
    .pend_orig_o(pend_o), .skip_unstack_o(skip_o), .push_additional_o(push_o),
    .rollback_additional_o(roll_o), .stack_fp_o(sfp_o), .clear_fp_o(clr_o),
    .thread_hold_o(hold_o), .callee_stacking_flag_o(cflag_o), .return_token_zero_o(tok_o),
    .continuation_field_o(cont_o), .dest_write_block_o(blk_o));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // sticky flags for one-cycle pulses
  always @(posedge clk) begin
    skip_seen <= rst ? 1'h0 : (skip_seen | (skip_o === 1'h1));
    clr_seen  <= rst ? 1'h0 : (clr_seen | (clr_o === 1'h1));
    roll_seen <= rst ? 1'h0 : (roll_seen | (roll_o === 1'h1));
    tok_seen  <= rst ? 1'h0 : (tok_seen | (tok_o === 1'h1));
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (wait_o !== 1'h0);
    rd_v = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic wait_take();
    do @(posedge clk); while (take_p !== 1'h1);
    got = got_w;
  endtask
  task automatic do_reset(input logic [31:0] c);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    bus(1'h1, REG_CTRL, c);
  endtask
  task automatic entry(input ltc_exc_t o, input ltc_exc_t l, input logic [3:0] d);
    @(posedge clk);
    nexc <= o;
    dly <= d;
    go_e <= 1'h1;
    @(posedge clk);
    go_e <= 1'h0;
    @(posedge clk);
    nexc <= l;
    wait_take();
    nexc <= '0;
  endtask
  task automatic ret(input logic [7:0] p, input ltc_exc_t l);
    @(posedge clk);
    ret_p <= p;
    dly <= 4'h2;
    go_r <= 1'h1;
    nexc <= l;
    @(posedge clk);
    go_r <= 1'h0;
    wait_take();
    nexc <= '0;
  endtask
  function automatic ltc_exc_t mk(input logic [8:0] n, input logic [7:0] p, input logic dv);
    mk = '{1'h1, n, p, 1'h0, dv};
  endfunction

  initial begin
    {rst, rd, wr, go_e, go_r, bsec, tsec, dbg, abort} = 9'h100;
    {addr, dly, wdata, pre_p, ret_p} = '0;
    nexc = '0;
    cont = '0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    chk_bit("callee_flag", 1'h1, cflag_o);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].wd);
      if (!rows[i].wr) chk_word("readdata", rows[i].ex, rd_v);
    end
    $display("registers done");
    do_reset(32'h2e);
    pre_p <= 8'h80;
    entry(mk(9'h020, 8'h40, 1'h0), mk(9'h021, 8'h10, 1'h0), 4'h3);
    chk_word("taken", 32'h021, 32'(got.num));
    chk_bit("pend_orig", 1'h1, pend_o);
    chk_bit("stack_fp", 1'h1, sfp_o);
    ret(8'h80, '0);
    chk_word("taken", 32'h020, 32'(got.num));
    $display("late arrival done");
    do_reset(32'h2e);
    entry(mk(9'h022, 8'h40, 1'h0), mk(9'h023, 8'h40, 1'h0), 4'h3);
    chk_word("taken", 32'h022, 32'(got.num));
    do_reset(32'h2e);
    entry(mk(9'h024, 8'h40, 1'h0), mk(9'h025, 8'h90, 1'h1), 4'h1);
    chk_word("taken", 32'(EXC_ESCALATION_FAULT), 32'(got.num));
    do_reset(32'h2e);
    dbg <= 1'h1;
    entry(mk(9'h024, 8'h40, 1'h0), mk(EXC_DBGMON, 8'h90, 1'h1), 4'h1);
    chk_word("taken", 32'h024, 32'(got.num));
    dbg <= 1'h0;
    do_reset(32'h26);
    entry(mk(9'h026, 8'h40, 1'h0), mk(9'h027, 8'h10, 1'h0), 4'h3);
    chk_word("taken", 32'h026, 32'(got.num));
    $display("entry arbitration done");
    do_reset(32'h2e);
    cont <= '{1'h1, 1'h0, 4'h5, 1'h1};
    entry(mk(9'h030, 8'h40, 1'h0), '0, 4'h1);
    @(posedge clk);
    chk_word("continuation", 32'h14, 32'(cont_o));
    ret(8'h80, mk(9'h031, 8'h10, 1'h0));
    chk_word("taken", 32'h031, 32'(got.num));
    @(posedge clk);
    chk_bit("skip_unstack", 1'h1, skip_seen);
    chk_bit("clear_fp", 1'h1, clr_seen);
    ret(8'h40, mk(9'h032, 8'h90, 1'h1));
    chk_word("taken", 32'(EXC_ESCALATION_FAULT), 32'(got.num));
    $display("tail-chain done");
    abort <= 1'h1;
    repeat (2) @(posedge clk);
    chk_bit("dest_block", 1'h1, blk_o);
    abort <= 1'h0;
    $display("load abort done");
    do_reset(32'h3e);
    bsec <= 1'h1;
    entry('{1'h1, 9'h050, 8'h40, 1'h0, 1'h0}, '{1'h1, 9'h051, 8'h10, 1'h1, 1'h0}, 4'h3);
    chk_word("taken", 32'h051, 32'(got.num));
    chk_bit("rollback", 1'h1, roll_seen);
    chk_bit("token_zero", 1'h0, tok_seen);
    do_reset(32'h2e);
    entry('{1'h1, 9'h050, 8'h40, 1'h0, 1'h0}, '{1'h1, 9'h051, 8'h10, 1'h1, 1'h0}, 4'h3);
    chk_bit("token_zero", 1'h1, tok_seen);
    chk_bit("rollback", 1'h0, roll_seen);
    $display("secure late arrival done");
    do_reset(32'h2e);
    entry('{1'h1, 9'h060, 8'h40, 1'h1, 1'h0}, '0, 4'h1);
    ret(8'h80, '{1'h1, 9'h061, 8'h10, 1'h0, 1'h0});
    chk_bit("push_additional", 1'h1, push_o);
    chk_bit("callee_flag", 1'h1, cflag_o);
    ret(8'h80, '{1'h1, 9'h062, 8'h10, 1'h1, 1'h0});
    chk_bit("callee_flag", 1'h0, cflag_o);
    ret(8'h80, '{1'h1, 9'h063, 8'h10, 1'h0, 1'h0});
    chk_bit("push_additional", 1'h0, push_o);
    chk_bit("callee_flag", 1'h1, cflag_o);
    $display("security tail-chain done");
    give_verdict();
  end
endmodule
